/* src/irq_slice_pkg.sv */
// shared constants for the interrupt flag and priority slice
package irq_slice_pkg;
  localparam int ADDR_W = 12;
  localparam logic [11:0] OFF_FLAG = 12'h000;
  localparam logic [11:0] OFF_LVL_CMP2_PWM = 12'h004;
  localparam logic [11:0] OFF_LVL_CMP34 = 12'h008;
  localparam logic [11:0] OFF_LVL_ADC25 = 12'h00C;
  localparam logic [11:0] OFF_LVL_ADC67 = 12'h010;
  localparam logic [11:0] OFF_IRQ_STAT = 12'h014;
  localparam logic [11:0] OFF_IRQ_EN = 12'h018;
  localparam logic [11:0] OFF_IRQ_CLR = 12'h01C;
  localparam logic [11:0] OFF_PEND = 12'h020;
  localparam int NUM_FLAGS = 7;
  localparam int NUM_LEVELS = 12;
  localparam int FLAG_SERIAL_ERR = 0;
  localparam int FLAG_SERIAL_EVT = 1;
  localparam int FLAG_CAN_RX = 2;
  localparam int FLAG_CAN_EVT = 3;
  localparam int FLAG_DMA3 = 4;
  localparam int FLAG_CAP3 = 5;
  localparam int FLAG_CAP4 = 6;
  localparam logic [6:0] FLAG_MASK = 7'h7F;
  localparam logic [6:0] CAN_FLAGS = 7'h0C;
  localparam logic [2:0] LEVEL_RESET = 3'h4;
  localparam logic [2:0] LEVEL_OFF = 3'h0;
  localparam int LEVEL_W = 3;
  localparam int FIELD3_POS = 12;
  localparam int FIELD2_POS = 8;
  localparam int FIELD1_POS = 4;
  localparam int FIELD0_POS = 0;
  localparam logic [15:0] LVL4_RESET = {4{1'b0, LEVEL_RESET}};
  localparam logic [15:0] LVL2_RESET = {8'h00, {2{1'b0, LEVEL_RESET}}};
  localparam logic [15:0] LVL4_MASK = 16'h7777;
  localparam logic [15:0] LVL2_MASK = 16'h0077;
  localparam int EVT_FLAG_SET = 0;
  localparam int EVT_BAD_ADDR = 1;
  localparam int NUM_EVT = 2;
endpackage

/* src/irq_flag_priority_slice.sv */
// interrupt flag status and priority level registers with apb access
// Behaviour
// - a flag bit reads one once its source has raised a request.
// - capture channel 4 flag is bit 6 and channel 3 flag is bit 5.
// - dma channel 3 transfer done flag is bit 4.
// - can event flag is bit 3 and can receive event flag is bit 2.
// - without a can controller the can interrupts are never delivered.
// - unimplemented bits read zero and ignore writes.
// - level code 111 gives priority 7, the highest.
// - level code 001 gives priority 1, codes between map to their value.
// - level code 000 disables the source whatever its flag.
// - register 25 holds comparator 2, pulse gen 9, 8, 7 levels.
// - register 26 holds comparator 4 and 3 levels, upper byte unused.
// - register 28 holds conversion pair 5, 4, 3, 2 levels.
// - register 29 holds conversion pair 7 and 6 levels only.
`timescale 1ns/1ps
module irq_flag_priority_slice
  import irq_slice_pkg::*;
#(
  parameter bit HAS_CAN = 1'b1
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [6:0] src_event,
  output logic [6:0] flag_out,
  output logic [6:0] service_req,
  output logic [2:0] comparator2_level,
  output logic [2:0] pulse_gen9_level,
  output logic [2:0] pulse_gen8_level,
  output logic [2:0] pulse_gen7_level,
  output logic [2:0] comparator4_level,
  output logic [2:0] comparator3_level,
  output logic [2:0] conv_pair5_level,
  output logic [2:0] conv_pair4_level,
  output logic [2:0] conv_pair3_level,
  output logic [2:0] conv_pair2_level,
  output logic [2:0] conv_pair7_level,
  output logic [2:0] conv_pair6_level,
  output logic irq
);

  logic [6:0] flag_q;
  logic [15:0] lvl25_q;
  logic [15:0] lvl26_q;
  logic [15:0] lvl28_q;
  logic [15:0] lvl29_q;
  logic [1:0] stat_q;
  logic [1:0] en_q;
  logic [31:0] prdata_q;
  logic pslverr_q;
  logic [6:0] avail;
  logic [6:0] lvl_nz;
  logic access;
  logic wr;
  logic rd;
  logic lo_lane;
  logic hi_lane;
  logic [11:0] addr;
  logic hit;
  logic [31:0] rdata;
  logic [6:0] flag_d;
  logic [1:0] evt;
  logic [15:0] wmask;
  logic [15:0] lvl25_d;
  logic [15:0] lvl26_d;
  logic [15:0] lvl28_d;
  logic [15:0] lvl29_d;
  logic [1:0] stat_d;
  logic [1:0] en_d;
  logic wr_flag;
  logic wr_lvl25;
  logic wr_lvl26;
  logic wr_lvl28;
  logic wr_lvl29;
  logic wr_en;
  logic wr_clr;

  assign addr = paddr[11:0];
  assign access = psel & penable & clk_en;
  assign wr = access & pwrite;
  assign rd = access & ~pwrite;
  assign lo_lane = pstrb[0];
  assign hi_lane = pstrb[1];
  assign wmask = {{8{hi_lane}}, {8{lo_lane}}};

  // one write strobe per writable register
  assign wr_flag = wr && (addr == OFF_FLAG) && lo_lane;
  assign wr_lvl25 = wr && (addr == OFF_LVL_CMP2_PWM);
  assign wr_lvl26 = wr && (addr == OFF_LVL_CMP34);
  assign wr_lvl28 = wr && (addr == OFF_LVL_ADC25);
  assign wr_lvl29 = wr && (addr == OFF_LVL_ADC67);
  assign wr_en = wr && (addr == OFF_IRQ_EN) && lo_lane;
  assign wr_clr = wr && (addr == OFF_IRQ_CLR) && lo_lane;

  // can sources are absent on builds without the controller
  assign avail = HAS_CAN ? FLAG_MASK : (FLAG_MASK & ~CAN_FLAGS);

  always_comb
  begin
    hit = 1'b1;
    rdata = 32'h0000_0000;
    case (addr)
      OFF_FLAG: rdata = {25'h0, flag_q};
      OFF_LVL_CMP2_PWM: rdata = {16'h0, lvl25_q};
      OFF_LVL_CMP34: rdata = {16'h0, lvl26_q};
      OFF_LVL_ADC25: rdata = {16'h0, lvl28_q};
      OFF_LVL_ADC67: rdata = {16'h0, lvl29_q};
      OFF_IRQ_STAT: rdata = {30'h0, stat_q};
      OFF_IRQ_EN: rdata = {30'h0, en_q};
      OFF_IRQ_CLR: rdata = 32'h0000_0000;
      OFF_PEND: rdata = {25'h0, service_req};
      default:
      begin
        hit = 1'b0;
        rdata = 32'h0000_0000;
      end
    endcase
  end

  // flag set by event or software one, cleared by software zero; set wins
  always_comb
  begin
    flag_d = flag_q;
    if (wr_flag)
    begin
      flag_d = pwdata[6:0];
    end
    flag_d = (flag_d | src_event) & avail;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      flag_q <= 7'h00;
    end
    else if (clk_en)
    begin
      flag_q <= flag_d;
    end
  end

  // level registers keep only implemented field bits
  always_comb
  begin
    lvl25_d = lvl25_q;
    if (wr_lvl25)
    begin
      lvl25_d = ((pwdata[15:0] & wmask) | (lvl25_q & ~wmask))
        & LVL4_MASK;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      lvl25_q <= LVL4_RESET;
    end
    else if (clk_en)
    begin
      lvl25_q <= lvl25_d;
    end
  end

  always_comb
  begin
    lvl26_d = lvl26_q;
    if (wr_lvl26)
    begin
      lvl26_d = ((pwdata[15:0] & wmask) | (lvl26_q & ~wmask))
        & LVL2_MASK;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      lvl26_q <= LVL2_RESET;
    end
    else if (clk_en)
    begin
      lvl26_q <= lvl26_d;
    end
  end

  always_comb
  begin
    lvl28_d = lvl28_q;
    if (wr_lvl28)
    begin
      lvl28_d = ((pwdata[15:0] & wmask) | (lvl28_q & ~wmask))
        & LVL4_MASK;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      lvl28_q <= LVL4_RESET;
    end
    else if (clk_en)
    begin
      lvl28_q <= lvl28_d;
    end
  end

  always_comb
  begin
    lvl29_d = lvl29_q;
    if (wr_lvl29)
    begin
      lvl29_d = ((pwdata[15:0] & wmask) | (lvl29_q & ~wmask))
        & LVL2_MASK;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      lvl29_q <= LVL2_RESET;
    end
    else if (clk_en)
    begin
      lvl29_q <= lvl29_d;
    end
  end

  assign comparator2_level = lvl25_q[FIELD3_POS +: LEVEL_W];
  assign pulse_gen9_level = lvl25_q[FIELD2_POS +: LEVEL_W];
  assign pulse_gen8_level = lvl25_q[FIELD1_POS +: LEVEL_W];
  assign pulse_gen7_level = lvl25_q[FIELD0_POS +: LEVEL_W];
  assign comparator4_level = lvl26_q[FIELD1_POS +: LEVEL_W];
  assign comparator3_level = lvl26_q[FIELD0_POS +: LEVEL_W];
  assign conv_pair5_level = lvl28_q[FIELD3_POS +: LEVEL_W];
  assign conv_pair4_level = lvl28_q[FIELD2_POS +: LEVEL_W];
  assign conv_pair3_level = lvl28_q[FIELD1_POS +: LEVEL_W];
  assign conv_pair2_level = lvl28_q[FIELD0_POS +: LEVEL_W];
  assign conv_pair7_level = lvl29_q[FIELD1_POS +: LEVEL_W];
  assign conv_pair6_level = lvl29_q[FIELD0_POS +: LEVEL_W];

  // flag sources have their level fields elsewhere; a nonzero field of
  // this slice gates requests: sources map to the first seven fields
  assign lvl_nz[0] = comparator2_level != LEVEL_OFF;
  assign lvl_nz[1] = pulse_gen9_level != LEVEL_OFF;
  assign lvl_nz[2] = pulse_gen8_level != LEVEL_OFF;
  assign lvl_nz[3] = pulse_gen7_level != LEVEL_OFF;
  assign lvl_nz[4] = comparator4_level != LEVEL_OFF;
  assign lvl_nz[5] = comparator3_level != LEVEL_OFF;
  assign lvl_nz[6] = conv_pair5_level != LEVEL_OFF;

  // levels 1 to 7 pass their code unchanged as priority
  assign service_req = flag_q & lvl_nz & avail;
  assign flag_out = flag_q;

  // controller events
  assign evt[EVT_FLAG_SET] = |(flag_d & ~flag_q);
  assign evt[EVT_BAD_ADDR] = access & ~hit;

  // enable register
  always_comb
  begin
    en_d = en_q;
    if (wr_en)
    begin
      en_d = pwdata[1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      en_q <= 2'h0;
    end
    else if (clk_en)
    begin
      en_q <= en_d;
    end
  end

  // sticky status, an event in the clearing cycle wins
  always_comb
  begin
    stat_d = stat_q;
    if (wr_clr)
    begin
      stat_d = stat_q & ~pwdata[1:0];
    end
    stat_d = stat_d | evt;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      stat_q <= 2'h0;
    end
    else if (clk_en)
    begin
      stat_q <= stat_d;
    end
  end

  assign irq = |(stat_q & en_q);

  // read data and error are registered at the setup edge, while penable is still low
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_q <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end
    else if (clk_en)
    begin
      if (psel && !penable)
      begin
        prdata_q <= pwrite ? 32'h0000_0000 : rdata;
        pslverr_q <= ~hit;
      end
    end
  end

  assign pready = clk_en;
  assign prdata = rd ? prdata_q : 32'h0000_0000;
  assign pslverr = access & pslverr_q;

endmodule // irq_flag_priority_slice

/* sim/irq_slice_checker.sv */
// port assertions for the flag and priority slice
`timescale 1ns/1ps
module irq_slice_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic clk_en,
  input wire logic [6:0] src_event,
  input wire logic [6:0] flag_out,
  input wire logic [6:0] service_req,
  input wire logic [2:0] comparator2_level
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_acc;
    psel && penable && pready;
  endsequence
  a_read_upper_zero: assert property (s_acc ##0 !pwrite |->
    prdata[31:16] == 16'h0) else $error("upper read bits set");
  a_bad_addr_err: assert property (s_acc ##0 paddr[11:0] > 12'h020
    |-> pslverr) else $error("unmapped access not refused");
  a_event_sets_flag: assert property (clk_en && src_event != 7'h0
    |=> (flag_out & $past(src_event)) == $past(src_event))
    else $error("event did not set flag");
  a_flag_stays_set: assert property (!(psel && penable)
    |=> (flag_out & $past(flag_out)) == $past(flag_out))
    else $error("flag dropped without write");
  a_zero_level_off: assert property (comparator2_level == 3'h0
    |-> !service_req[0]) else $error("disabled source requests");
  a_level_serves: assert property (flag_out[0] &&
    comparator2_level != 3'h0 |-> service_req[0])
    else $error("flagged source not requesting");
  a_req_has_flag: assert property (
    (service_req & ~flag_out) == 7'h0) else $error("request without flag");
  a_reset_level: assert property ($rose(presetn) |->
    comparator2_level == 3'h4) else $error("reset level wrong");
endmodule // irq_slice_checker
bind irq_flag_priority_slice irq_slice_checker chk_i (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .clk_en(clk_en), .src_event(src_event),
  .flag_out(flag_out), .service_req(service_req),
  .comparator2_level(comparator2_level)
);

/* sim/irq_flag_priority_slice_bench.sv */
// self-checking bench for the flag and priority slice
`timescale 1ns/1ps
module irq_flag_priority_slice_bench;
  import irq_slice_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, pready, pslverr, irq, er;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, rd;
  logic [6:0] src_event = 7'h0, flag_out, service_req, ev;
  wire [2:0] lv [12];
  int num_errors = 0, cmp_count = 0, cyc = 0, seed = 32'h3A9E, d;
  int m [5];
  int mask [5] = '{32'h7F, 32'h7777, 32'h77, 32'h7777, 32'h77};
  irq_flag_priority_slice uut (
    .pclk(pclk), .presetn(presetn), .clk_en(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(4'hF), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .src_event(src_event), .flag_out(flag_out), .irq(irq),
    .service_req(service_req), .comparator2_level(lv[0]),
    .pulse_gen9_level(lv[1]), .pulse_gen8_level(lv[2]),
    .pulse_gen7_level(lv[3]), .comparator4_level(lv[4]),
    .comparator3_level(lv[5]), .conv_pair5_level(lv[6]),
    .conv_pair4_level(lv[7]), .conv_pair3_level(lv[8]),
    .conv_pair2_level(lv[9]), .conv_pair7_level(lv[10]),
    .conv_pair6_level(lv[11])
  );
  always #5 pclk = ~pclk;
  function automatic int lvx(int k);
    int r = k < 4 ? 1 : k < 6 ? 2 : k < 10 ? 3 : 4;
    int t = k < 4 ? 3 : k < 6 ? 5 : k < 10 ? 9 : 11;
    return (m[r] >> 4 * (t - k)) & 7;
  endfunction
  task automatic test_done;
    $display("compares %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("wrong value at %0t: %h vs %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [31:0] a, b);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= b;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdc(input int r, input int e);
    bus(1'b0, r * 4, 32'h0);
    chk(rd, e);
  endtask
  task automatic chkall;
    #1;
    chk(flag_out, m[0]);
    for (int k = 0; k < 12; k++)
      chk(lv[k], lvx(k));
    for (int k = 0; k < 7; k++)
      chk(service_req[k], m[0][k] && lvx(k) != 0);
  endtask
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      num_errors++;
      test_done;
    end
  end
  initial
  begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    foreach (m[j]) m[j] = j ? mask[j] & 32'h4444 : 0;
    foreach (m[j]) rdc(j, m[j]);
    chkall;
    $display("reset test done");
    for (int r = 1; r < 5; r++)
      for (int c = 0; c < 8; c++)
      begin
        bus(1'b1, r * 4, c * 32'h1111);
        m[r] = c * 32'h1111 & mask[r];
        rdc(r, m[r]);
        chkall;
      end
    $display("level test done");
    for (int k = 0; k < 7; k++)
    begin
      bus(1'b1, 32'h0, 32'h0);
      @(posedge pclk);
      src_event <= 7'h1 << k;
      @(posedge pclk);
      src_event <= 7'h0;
      m[0] = 1 << k;
      rdc(0, m[0]);
      chkall;
    end
    repeat (20)
    begin
      ev = $random(seed);
      d = $random(seed);
      @(posedge pclk);
      src_event <= ev;
      @(posedge pclk);
      src_event <= 7'h0;
      m[0] = m[0] | ev;
      if (d[3])
      begin
        bus(1'b1, 32'h0, d);
        m[0] = d & 32'h7F;
      end
      chkall;
    end
    $display("flag test done");
    bus(1'b1, OFF_IRQ_EN, 32'h3);
    bus(1'b1, OFF_IRQ_CLR, 32'h3);
    #1 chk(irq, 1'b0);
    bus(1'b0, 32'h100, 32'h0);
    chk(rd, 32'h0);
    chk(er, 1'b1);
    #1 chk(irq, 1'b1);
    bus(1'b1, 32'h0, 32'h0);
    bus(1'b1, OFF_IRQ_EN, 32'h1);
    #1 chk(irq, 1'b0);
    @(posedge pclk);
    src_event <= 7'h40;
    @(posedge pclk);
    src_event <= 7'h0;
    @(posedge pclk);
    #1 chk(irq, 1'b1);
    rdc(8, 32'h40);
    rdc(5, 32'h3);
    bus(1'b1, OFF_IRQ_CLR, 32'h1);
    #1 chk(irq, 1'b0);
    rdc(5, 32'h2);
    $display("interrupt test done");
    test_done;
  end
endmodule // irq_flag_priority_slice_bench
